// file: core/dsad_pkg.sv
// Constants and carriers for the data space access decoder.
// Assumes a single core clock; included before dsad_core.
package dsad_pkg;
    localparam int PROG_ADDR_W = 24;
    localparam logic [23:0] PROG_RESET_ADDR = 24'h000000;
    localparam logic [23:0] PROG_START_VEC = 24'h000002;
    localparam logic [23:0] IVT_LO = 24'h000004;
    localparam logic [23:0] IVT_HI = 24'h0000ff;
    localparam logic [23:0] AIVT_LO = 24'h000100;
    localparam logic [23:0] AIVT_HI = 24'h0001ff;
    localparam logic [23:0] PC_STEP = 24'h000002;
    localparam int EA_W = 16;
    localparam int PSV_BIT = 15;
    localparam logic [15:0] SFR_LAST = 16'h07ff;
    localparam logic [15:0] NEAR_LAST = 16'h1fff;
    localparam int NEAR_FIELD_W = 13;
    localparam logic [15:0] BYTE_STEP = 16'h0001;
    localparam logic [15:0] WORD_STEP = 16'h0002;
    localparam int RAM_BYTES = 16384;
    localparam logic [15:0] RAM_BASE = 16'h0800;
    localparam int RAM_BYTES_MAX = 32768;
    localparam int RAM_BYTES_MIN = 4096;
    localparam int DMA_BYTES = 2048;

    typedef struct packed {
        logic valid;
        logic wr;
        logic byte_op;
        logic [15:0] effective_addr;
        logic [15:0] wdata;
    } dsad_req_t;

    typedef struct packed {
        logic valid;
        logic [15:0] data;
    } dsad_rsp_t;
endpackage

// file: core/dsad_core.sv
// Data space access decoder: X/Y ADDR_GEN_UNIT ports, byte lanes, DMA RAM port,
// address error pulse, program counter stepping and vector region flags.
// Assumes all requesters run on mclk_i; SFR reads come back on sfr_rdata_i.
module dsad_core #(
    parameter int RAM_BYTES = dsad_pkg::RAM_BYTES,
    parameter int DMA_BYTES = dsad_pkg::DMA_BYTES
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic pc_step_i,
    input wire logic pc_dir_dn_i,
    input wire logic pc_load_i,
    input wire logic [23:0] pc_load_addr_i,
    output logic [23:0] program_counter_o,
    output logic pc_in_ivt_o,
    output logic pc_in_aivt_o,
    input wire dsad_pkg::dsad_req_t x_req_i,
    input wire logic x_bitrev_i,
    input wire logic [15:0] y_addr_i,
    input wire logic y_rd_i,
    input wire logic [15:0] ptr_i,
    input wire logic ptr_byte_i,
    output logic [15:0] ptr_inc_o,
    input wire logic [15:0] wreg_old_i,
    output logic [15:0] wreg_load_o,
    input wire logic near_dir_i,
    input wire logic [12:0] near_field_i,
    input wire logic [15:0] full_field_i,
    output logic [15:0] direct_ea_o,
    input wire logic [15:0] sfr_rdata_i,
    output logic sfr_wr_o,
    output logic [1:0] sfr_be_o,
    output logic [15:0] sfr_addr_o,
    output logic [15:0] sfr_wdata_o,
    output logic psv_rd_o,
    input wire logic [15:0] psv_rdata_i,
    output dsad_pkg::dsad_rsp_t x_rsp_o,
    output dsad_pkg::dsad_rsp_t y_rsp_o,
    input wire logic dma_wr_i,
    input wire logic dma_rd_i,
    input wire logic [15:0] dma_addr_i,
    input wire logic [1:0] dma_be_i,
    input wire logic [15:0] dma_wdata_i,
    output logic [15:0] dma_rdata_o,
    output logic dma_lost_o,
    output logic addr_err_o
);
    localparam int WORDS = RAM_BYTES / 2;
    localparam int AW = $clog2(WORDS);
    localparam logic [15:0] RAM_END = 16'(RAM_BYTES - 1);
    localparam logic [15:0] DMA_BASE = 16'(RAM_BYTES - DMA_BYTES);

    // Sizes the decode cannot serve are refused at elaboration
    if (RAM_BYTES > dsad_pkg::RAM_BYTES_MAX) begin : g_chk_ram_max
        $error("dsad_core: RAM_BYTES must not reach the visibility window");
    end
    if (RAM_BYTES < dsad_pkg::RAM_BYTES_MIN) begin : g_chk_ram_min
        $error("dsad_core: RAM_BYTES too small for registers and DMA RAM");
    end
    if ((RAM_BYTES & (RAM_BYTES - 1)) != 0) begin : g_chk_ram_pow2
        $error("dsad_core: RAM_BYTES must be a power of two");
    end
    if (DMA_BYTES > RAM_BYTES - int'(dsad_pkg::RAM_BASE)) begin : g_chk_dma_max
        $error("dsad_core: DMA_BYTES larger than the RAM above the registers");
    end
    if (DMA_BYTES < 2 || DMA_BYTES % 2 != 0) begin : g_chk_dma_even
        $error("dsad_core: DMA_BYTES must be a whole number of words");
    end

    // Region of an X access
    typedef enum logic [1:0] {
        DSAD_RGN_SFR = 2'b00,
        DSAD_RGN_RAM = 2'b01,
        DSAD_RGN_NONE = 2'b11,
        DSAD_RGN_PSV = 2'b10
    } dsad_region_t;

    typedef struct packed {
        logic [23:0] pc;
        logic xvalid;
        logic yvalid;
        logic xsel_psv;
        logic xsel_sfr;
        logic xhi;
        logic xbyte;
        logic xzero;
        logic yzero;
        logic dvalid;
        logic lost;
        logic err;
    } dsad_state_t;

    dsad_state_t s_r, s_nxt;
    dsad_region_t x_region;
    logic [15:0] xw_rd, yw_rd, dw_rd, x_word;
    logic [15:0] x_rev, x_ea, x_rw;
    logic x_misal, x_in_ram, x_in_sfr, x_psv, x_wr_ok, y_in_ram;
    logic [AW-1:0] xi, yi, di;
    logic [1:0] x_be, d_be, d_clash;
    logic dma_ok;

    // Bit-reversed ordering applies to X writes only; bit 0 keeps the lane
    assign x_rev[0] = x_req_i.effective_addr[0];
    for (genvar b = 1; b < dsad_pkg::EA_W; b++) begin : g_rev
        assign x_rev[b] = x_req_i.effective_addr[dsad_pkg::EA_W - b];
    end
    assign x_ea = (x_bitrev_i && x_req_i.wr) ? x_rev : x_req_i.effective_addr;

    always_comb begin
        if (x_ea[dsad_pkg::PSV_BIT]) begin
            x_region = DSAD_RGN_PSV;
        end else if (x_ea <= dsad_pkg::SFR_LAST) begin
            x_region = DSAD_RGN_SFR;
        end else if (x_ea <= RAM_END) begin
            x_region = DSAD_RGN_RAM;
        end else begin
            x_region = DSAD_RGN_NONE;
        end
    end

    assign x_psv = x_region == DSAD_RGN_PSV;
    assign x_in_sfr = x_region == DSAD_RGN_SFR;
    assign x_in_ram = x_region == DSAD_RGN_RAM;
    assign x_misal = x_req_i.valid && !x_req_i.byte_op && x_ea[0];
    assign y_in_ram = y_addr_i >= dsad_pkg::RAM_BASE && y_addr_i <= RAM_END;
    assign x_wr_ok = x_req_i.valid && x_req_i.wr && !x_misal;
    assign xi = x_ea[AW:1];
    assign yi = y_addr_i[AW:1];
    assign di = dma_addr_i[AW:1];
    // Byte writes touch only the lane matching the address
    assign x_be = x_req_i.byte_op ? {x_ea[0], ~x_ea[0]} : 2'b11;
    assign x_rw = x_req_i.byte_op ? {x_req_i.wdata[7:0], x_req_i.wdata[7:0]}
                                  : x_req_i.wdata;
    assign dma_ok = dma_addr_i >= DMA_BASE && dma_addr_i <= RAM_END;

    // Same word, same lane: the CPU write wins and the DMA lane is dropped
    always_comb begin
        d_clash = 2'b00;
        if (x_wr_ok && x_in_ram && dma_ok && xi == di) begin
            d_clash = x_be;
        end
        d_be = dma_be_i & ~d_clash;
    end

    assign sfr_wr_o = x_wr_ok && x_in_sfr;
    assign sfr_be_o = x_be;
    assign sfr_addr_o = {x_ea[15:1], 1'b0};
    assign sfr_wdata_o = x_rw;
    assign psv_rd_o = x_req_i.valid && !x_req_i.wr && x_psv;

    // One byte-wide array per lane: shared word decode, separate write lines
    for (genvar g = 0; g < 2; g++) begin : g_lane
        logic [7:0] mem [WORDS];
        always_ff @(posedge mclk_i) begin
            if (x_wr_ok && x_in_ram && x_be[g]) begin
                mem[xi] <= x_rw[8*g +: 8];
            end
            if (dma_wr_i && dma_ok && d_be[g]) begin
                mem[di] <= dma_wdata_i[8*g +: 8];
            end
            xw_rd[8*g +: 8] <= mem[xi];
            yw_rd[8*g +: 8] <= mem[yi];
            dw_rd[8*g +: 8] <= mem[di];
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
            s_r.pc <= dsad_pkg::PROG_RESET_ADDR;
        end else begin
            s_r <= s_nxt;
        end
    end

    always_comb begin
        s_nxt = s_r;
        // Program counter: a load wins over a step
        if (pc_load_i) begin
            s_nxt.pc = {pc_load_addr_i[23:1], 1'b0};
        end else if (pc_step_i && pc_dir_dn_i) begin
            s_nxt.pc = s_r.pc - dsad_pkg::PC_STEP;
        end else if (pc_step_i) begin
            s_nxt.pc = s_r.pc + dsad_pkg::PC_STEP;
        end
        // X read: how to treat the word when it comes back
        s_nxt.xvalid = x_req_i.valid && !x_req_i.wr;
        s_nxt.xsel_psv = x_psv;
        s_nxt.xsel_sfr = x_in_sfr;
        s_nxt.xhi = x_ea[0];
        s_nxt.xbyte = x_req_i.byte_op;
        s_nxt.xzero = !x_in_ram;
        // Y read
        s_nxt.yvalid = y_rd_i;
        s_nxt.yzero = !y_in_ram;
        // DMA port
        s_nxt.dvalid = dma_rd_i && dma_ok;
        s_nxt.lost = dma_wr_i && dma_ok && (d_be != dma_be_i);
        s_nxt.err = x_misal;
    end

    // Read word of the X port, by the region noted with the request
    always_comb begin
        if (s_r.xsel_psv) begin
            x_word = psv_rdata_i;
        end else if (s_r.xsel_sfr) begin
            x_word = sfr_rdata_i;
        end else if (s_r.xzero) begin
            x_word = 16'h0000;
        end else begin
            x_word = xw_rd;
        end
    end

    // Byte reads land on the low lane with zero above
    always_comb begin
        x_rsp_o.valid = s_r.xvalid;
        if (!s_r.xbyte) begin
            x_rsp_o.data = x_word;
        end else if (s_r.xhi) begin
            x_rsp_o.data = {8'h00, x_word[15:8]};
        end else begin
            x_rsp_o.data = {8'h00, x_word[7:0]};
        end
    end

    always_comb begin
        y_rsp_o.valid = s_r.yvalid;
        if (s_r.yzero) begin
            y_rsp_o.data = 16'h0000;
        end else begin
            y_rsp_o.data = yw_rd;
        end
    end

    // Vector region flags follow the registered program counter
    always_comb begin
        pc_in_ivt_o = 1'b0;
        pc_in_aivt_o = 1'b0;
        if (s_r.pc >= dsad_pkg::IVT_LO && s_r.pc <= dsad_pkg::IVT_HI) begin
            pc_in_ivt_o = 1'b1;
        end
        if (s_r.pc >= dsad_pkg::AIVT_LO && s_r.pc <= dsad_pkg::AIVT_HI) begin
            pc_in_aivt_o = 1'b1;
        end
    end

    // Near field reaches the low 8K only; the full field the whole space
    always_comb begin
        if (near_dir_i) begin
            direct_ea_o = {3'h0, near_field_i};
        end else begin
            direct_ea_o = full_field_i;
        end
    end

    // Lower even word addressed here; the odd upper word lives outside
    assign program_counter_o = s_r.pc;
    assign ptr_inc_o = ptr_i + (ptr_byte_i ? dsad_pkg::BYTE_STEP : dsad_pkg::WORD_STEP);
    assign wreg_load_o = {wreg_old_i[15:8], x_rsp_o.data[7:0]};
    assign dma_rdata_o = s_r.dvalid ? dw_rd : 16'h0000;
    assign dma_lost_o = s_r.lost;
    assign addr_err_o = s_r.err;
endmodule

// file: bench/dsad_core_properties.sv
// Port checker for dsad_core.
// Assumes a bind onto dsad_core; one clock, synchronous reset.
module dsad_core_properties (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic pc_step_i,
    input wire logic pc_dir_dn_i,
    input wire logic pc_load_i,
    input wire logic [23:0] program_counter_o,
    input wire logic pc_in_ivt_o,
    input wire logic pc_in_aivt_o,
    input wire dsad_pkg::dsad_req_t x_req_i,
    input wire dsad_pkg::dsad_rsp_t x_rsp_o,
    input wire logic [15:0] ptr_i,
    input wire logic ptr_byte_i,
    input wire logic [15:0] ptr_inc_o,
    input wire logic [15:0] wreg_old_i,
    input wire logic [15:0] wreg_load_o,
    input wire logic addr_err_o
);
    logic mis;
    assign mis = x_req_i.valid & ~x_req_i.byte_op & x_req_i.effective_addr[0];
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_rst_pc;
        $rose(rst_n_i) |-> program_counter_o == 24'h000000;
    endproperty
    property p_step_up;
        pc_step_i && !pc_load_i && !pc_dir_dn_i
            |=> program_counter_o == $past(program_counter_o) + 24'h000002;
    endproperty
    property p_pc_even;
        program_counter_o[0] == 1'b0;
    endproperty
    property p_ivt;
        pc_in_ivt_o == (program_counter_o >= 24'h000004 && program_counter_o <= 24'h0000ff);
    endproperty
    property p_aivt;
        pc_in_aivt_o == (program_counter_o >= 24'h000100 && program_counter_o <= 24'h0001ff);
    endproperty
    property p_ptr;
        ptr_inc_o == ptr_i + (ptr_byte_i ? 16'h0001 : 16'h0002);
    endproperty
    property p_err;
        mis |=> addr_err_o;
    endproperty
    property p_err_pulse;
        addr_err_o |-> $past(mis);
    endproperty
    property p_wreg;
        wreg_load_o == {wreg_old_i[15:8], x_rsp_o.data[7:0]};
    endproperty
    a_rst_pc: assert property (p_rst_pc) else $error("pc not zero after reset");
    a_step_up: assert property (p_step_up) else $error("pc step wrong");
    a_pc_even: assert property (p_pc_even) else $error("pc odd");
    a_ivt: assert property (p_ivt) else $error("ivt flag wrong");
    a_aivt: assert property (p_aivt) else $error("aivt flag wrong");
    a_ptr: assert property (p_ptr) else $error("pointer step wrong");
    a_err: assert property (p_err) else $error("no address error");
    a_err_pulse: assert property (p_err_pulse) else $error("stray address error");
    a_wreg: assert property (p_wreg) else $error("byte load lane wrong");
    c_mis: cover property (mis);
    c_rsp: cover property (x_rsp_o.valid);
    c_aivt: cover property (pc_in_aivt_o);
endmodule
bind dsad_core dsad_core_properties i_props (.mclk_i, .rst_n_i, .pc_step_i, .pc_dir_dn_i,
    .pc_load_i, .program_counter_o, .pc_in_ivt_o, .pc_in_aivt_o, .x_req_i, .x_rsp_o, .ptr_i,
    .ptr_byte_i, .ptr_inc_o, .wreg_old_i, .wreg_load_o, .addr_err_o);

// file: bench/dsad_sfr_model.sv
// Far side: one peripheral register word and a fixed visibility word.
// Assumes write strobes from dsad_core on mclk_i.
module dsad_sfr_model (
    input wire logic mclk_i,
    input wire logic sfr_wr_i,
    input wire logic [1:0] sfr_be_i,
    input wire logic [15:0] sfr_wdata_i,
    output logic [15:0] sfr_rdata_o,
    output logic [15:0] psv_rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] word_r = 16'h0000;
    assign sfr_rdata_o = word_r;
    assign psv_rdata_o = 16'h5a5a;
    always @(posedge mclk_i) begin
        if (sfr_wr_i && sfr_be_i[0])
            word_r[7:0] <= sfr_wdata_i[7:0];
        if (sfr_wr_i && sfr_be_i[1])
            word_r[15:8] <= sfr_wdata_i[15:8];
    end
endmodule

// file: bench/dsad_core_test.sv
// Self-checking bench for dsad_core.
// Assumes dsad_pkg, the checker and the far-side model compiled first.
module dsad_core_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic pc_step_i = 1'b0;
    logic pc_dir_dn_i = 1'b0;
    logic pc_load_i = 1'b0;
    logic [23:0] pc_load_addr_i = 24'h000000;
    logic [23:0] program_counter_o;
    dsad_pkg::dsad_req_t x_req_i = '0;
    logic x_bitrev_i = 1'b0;
    logic y_rd_i = 1'b0;
    logic ptr_byte_i = 1'b0;
    logic near_dir_i = 1'b0;
    logic dma_wr_i = 1'b0;
    logic dma_rd_i = 1'b0;
    logic [1:0] dma_be_i = 2'b00;
    logic [12:0] near_field_i = 13'h0000;
    logic [15:0] y_addr_i = '0, ptr_i = '0, wreg_old_i = '0, full_field_i = '0;
    logic [15:0] dma_addr_i = '0, dma_wdata_i = '0;
    logic [15:0] ptr_inc_o, wreg_load_o, direct_ea_o, sfr_rdata_i, sfr_addr_o;
    logic [15:0] sfr_wdata_o, psv_rdata_i, dma_rdata_o;
    logic pc_in_ivt_o, pc_in_aivt_o, sfr_wr_o, psv_rd_o, dma_lost_o, addr_err_o;
    logic [1:0] sfr_be_o;
    dsad_pkg::dsad_rsp_t x_rsp_o, y_rsp_o;
    int fail_count = 0;
    int tests_run = 0;
    dsad_core i_dut (.mclk_i, .rst_n_i, .pc_step_i, .pc_dir_dn_i, .pc_load_i, .pc_load_addr_i,
        .program_counter_o, .pc_in_ivt_o, .pc_in_aivt_o, .x_req_i, .x_bitrev_i, .y_addr_i,
        .y_rd_i, .ptr_i, .ptr_byte_i, .ptr_inc_o, .wreg_old_i, .wreg_load_o, .near_dir_i,
        .near_field_i, .full_field_i, .direct_ea_o, .sfr_rdata_i, .sfr_wr_o, .sfr_be_o,
        .sfr_addr_o, .sfr_wdata_o, .psv_rd_o, .psv_rdata_i, .x_rsp_o, .y_rsp_o, .dma_wr_i,
        .dma_rd_i, .dma_addr_i, .dma_be_i, .dma_wdata_i, .dma_rdata_o, .dma_lost_o, .addr_err_o);
    dsad_sfr_model i_far (.mclk_i, .sfr_wr_i(sfr_wr_o), .sfr_be_i(sfr_be_o),
        .sfr_wdata_i(sfr_wdata_o), .sfr_rdata_o(sfr_rdata_i), .psv_rdata_o(psv_rdata_i));
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    task automatic wrap_up();
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic step();
        @(posedge mclk_i);
        #1;
    endtask
    task automatic xacc(input logic wr, input logic bo, input logic [15:0] a, input logic [15:0] d);
        x_req_i = '{1'b1, wr, bo, a, d};
        step();
        x_req_i.valid = 1'b0;
    endtask
    task automatic xrd(input logic bo, input logic [15:0] a, input logic [15:0] exp);
        xacc(1'b0, bo, a, 16'h0000);
        chk("x_valid", 24'h1, {23'h0, x_rsp_o.valid});
        chk("x_data", {8'h00, exp}, {8'h00, x_rsp_o.data});
    endtask
    task automatic t_pc();
        chk("pc_reset", 24'h000000, program_counter_o);
        pc_step_i = 1'b1;
        step();
        step();
        pc_step_i = 1'b0;
        chk("pc_up", 24'h000004, program_counter_o);
        chk("ivt", 24'h1, {23'h0, pc_in_ivt_o});
        pc_load_i = 1'b1;
        pc_load_addr_i = 24'h000101;
        step();
        pc_load_i = 1'b0;
        chk("pc_load", 24'h000100, program_counter_o);
        chk("aivt", 24'h1, {23'h0, pc_in_aivt_o});
        pc_step_i = 1'b1;
        pc_dir_dn_i = 1'b1;
        step();
        pc_step_i = 1'b0;
        pc_dir_dn_i = 1'b0;
        chk("pc_dn", 24'h0000fe, program_counter_o);
        rst_n_i = 1'b0;
        step();
        chk("pc_rst2", 24'h000000, program_counter_o);
        rst_n_i = 1'b1;
    endtask
    task automatic t_mem();
        wreg_old_i = 16'h7777;
        xacc(1'b1, 1'b0, 16'h0900, 16'ha1b2);
        xacc(1'b1, 1'b1, 16'h0901, 16'hcccc);
        xacc(1'b1, 1'b0, 16'h0902, 16'h1234);
        xrd(1'b0, 16'h0900, 16'hccb2);
        xrd(1'b1, 16'h0901, 16'h00cc);
        chk("wreg", 24'h0077cc, {8'h00, wreg_load_o});
        xacc(1'b1, 1'b0, 16'h0903, 16'h5555);
        chk("err_wr", 24'h1, {23'h0, addr_err_o});
        xacc(1'b0, 1'b0, 16'h0905, 16'h0000);
        chk("err_rd", 24'h1, {23'h0, addr_err_o});
        chk("rd_done", 24'h1, {23'h0, x_rsp_o.valid});
        y_addr_i = 16'h0900;
        y_rd_i = 1'b1;
        xrd(1'b0, 16'h0902, 16'h1234);
        y_rd_i = 1'b0;
        chk("y_data", 24'h00ccb2, {8'h00, y_rsp_o.data});
        chk("y_valid", 24'h1, {23'h0, y_rsp_o.valid});
        xrd(1'b0, 16'h4000, 16'h0000);
        xacc(1'b1, 1'b0, 16'h0010, 16'h0f0e);
        xrd(1'b0, 16'h0010, 16'h0f0e);
        x_req_i = '{1'b1, 1'b1, 1'b1, 16'h0011, 16'h00aa};
        #1;
        chk("sfr_addr", 24'h000010, {8'h00, sfr_addr_o});
        chk("sfr_be", 24'h2, {22'h0, sfr_be_o});
        step();
        x_req_i.valid = 1'b0;
        xrd(1'b0, 16'h0010, 16'haa0e);
        x_req_i = '{1'b1, 1'b0, 1'b0, 16'h8000, 16'h0000};
        #1;
        chk("psv_rd", 24'h1, {23'h0, psv_rd_o});
        step();
        x_req_i.valid = 1'b0;
        chk("psv_data", 24'h005a5a, {8'h00, x_rsp_o.data});
        x_bitrev_i = 1'b1;
        x_req_i = '{1'b1, 1'b1, 1'b0, 16'h00a0, 16'hbeef};
        #1;
        chk("rev_sfr", 24'h0, {23'h0, sfr_wr_o});
        step();
        x_req_i.valid = 1'b0;
        x_bitrev_i = 1'b0;
        xrd(1'b0, 16'h0a00, 16'hbeef);
    endtask
    task automatic t_dma();
        x_req_i = '{1'b1, 1'b1, 1'b0, 16'h3800, 16'h1111};
        {dma_wr_i, dma_addr_i, dma_be_i, dma_wdata_i} = {1'b1, 16'h3800, 2'b11, 16'h2222};
        {ptr_i, ptr_byte_i, near_dir_i, near_field_i} = {16'h0010, 1'b1, 1'b1, 13'h1abc};
        step();
        x_req_i.valid = 1'b0;
        dma_wr_i = 1'b0;
        chk("lost", 24'h1, {23'h0, dma_lost_o});
        chk("ptr", 24'h000011, {8'h00, ptr_inc_o});
        chk("near", 24'h001abc, {8'h00, direct_ea_o});
        dma_rd_i = 1'b1;
        step();
        dma_rd_i = 1'b0;
        chk("dma_rd", 24'h001111, {8'h00, dma_rdata_o});
    endtask
    initial begin
        #20000;
        fail_count++;
        wrap_up();
    end
    initial begin
        repeat (20) step();
        rst_n_i = 1'b1;
        t_pc();
        t_mem();
        t_dma();
        wrap_up();
    end
endmodule
